// >>> sfcmd_pkg.sv
// Functional notes
// - Status readback streams the status byte repeatedly
// - Config readback sends register one, then two
// - Pause opcodes suspend busy work; resume opcodes continue it
// - Signature read: three dummies, then device byte
// - Combined read: two dummies, address, identifier bytes
// - Address zero: manufacturer first; one: device first
// - Entry opcode enters secured area; exit leaves
// - Memory reset needs reset-arm immediately before
// - Any command between arm and reset cancels
`default_nettype none
package sfcmd_pkg;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_SET_WRITE_LATCH   = 8'h06;
  localparam logic [7:0] OP_CLEAR_WRITE_LATCH = 8'h04;
  localparam logic [7:0] OP_STATUS_READBACK   = 8'h05;
  localparam logic [7:0] OP_CONFIG_READBACK   = 8'h15;
  localparam logic [7:0] OP_PAUSE_A           = 8'h75;
  localparam logic [7:0] OP_PAUSE_B           = 8'hb0;
  localparam logic [7:0] OP_RESUME_A          = 8'h7a;
  localparam logic [7:0] OP_RESUME_B          = 8'h30;
  localparam logic [7:0] OP_SIGNATURE_READ    = 8'hab;
  localparam logic [7:0] OP_COMBINED_ID_READ  = 8'h90;
  localparam logic [7:0] OP_SECURE_ENTRY      = 8'hb1;
  localparam logic [7:0] OP_SECURE_EXIT       = 8'hc1;
  localparam logic [7:0] OP_SECURITY_LOCK     = 8'h2f;
  localparam logic [7:0] OP_RESET_ARM         = 8'h66;
  localparam logic [7:0] OP_RESET_MEMORY      = 8'h99;

  // ----------------------------------------------------------------
  // Frame counting
  // ----------------------------------------------------------------
  localparam logic [2:0] CNT_ZERO        = 3'h0;  // No byte yet / bit 0
  localparam logic [2:0] CNT_OPCODE_ONLY = 3'h1;  // Exactly one byte seen
  localparam logic [2:0] CNT_ID_ADDR     = 3'h3;  // Index of last dummy/address byte
  localparam logic [2:0] CNT_SAT         = 3'h4;  // Byte counter saturates here
  localparam logic [2:0] BIT_LAST        = 3'h7;  // Last bit of a byte
  localparam logic [7:0] ADDR_MFR_FIRST  = 8'h00;
  localparam logic [7:0] ADDR_DEV_FIRST  = 8'h01;
  localparam logic [7:0] DATA_IDLE       = 8'h00; // Driven when nothing to send
  localparam logic [2:0] PIN_IDLE        = 3'h2;  // {sclk, cs_n, si} at rest

  // ----------------------------------------------------------------
  // Control state carried out of the block
  // ----------------------------------------------------------------
  typedef struct packed {
    logic write_enable_latch;
    logic secure_area_mode;
    logic lock_down;
    logic suspended;
  } sfcmd_ctl_type;

  localparam sfcmd_ctl_type CTL_RESET = '0;

endpackage : sfcmd_pkg
`default_nettype wire

// >>> sfcmd_out_shifter.sv
`timescale 1ns/100ps
`default_nettype none
module sfcmd_out_shifter #(
  parameter int WIDTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  input  wire logic             load,   // Take new word, MSB appears at once
  input  wire logic             shift,  // Advance one bit
  input  wire logic [WIDTH-1:0] data,
  output logic                  so
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (WIDTH < 2) begin : g_bad_width
    $error("sfcmd_out_shifter needs WIDTH of at least 2");
  end

  logic [WIDTH-1:0] sr;  // Output shift register

  // Load has priority so a word boundary never loses its MSB
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sr <= '0;
    end else if (load) begin
      sr <= data;
    end else if (shift) begin
      sr <= {sr[WIDTH-2:0], 1'b0};
    end
  end

  assign so = sr[WIDTH-1];

endmodule : sfcmd_out_shifter
`default_nettype wire

// >>> sfcmd_top.sv
`timescale 1ns/100ps
`default_nettype none
module sfcmd_top
  import sfcmd_pkg::*;
#(
  parameter logic [7:0] MANUFACTURER_ID = 8'h5a,  // Arbitrary value
  parameter logic [7:0] DEVICE_ID       = 8'ha5   // Arbitrary value
) (
  input  wire logic          sys_clk,
  input  wire logic          resetn,
  input  wire logic          sclk,
  input  wire logic          cs_n,
  input  wire logic          si,
  input  wire logic [7:0]    status_reg,
  input  wire logic [7:0]    config1,
  input  wire logic [7:0]    config2,
  input  wire logic          array_busy,
  output logic               so,
  output logic               so_oe_n,
  output sfcmd_ctl_type      ctl,
  output logic               suspend_pulse,
  output logic               resume_pulse,
  output logic               memory_reset_pulse
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pin_meta;    // First stage, read only by pin_sync
  logic [2:0] pin_sync;    // {sclk, cs_n, si} in sys_clk domain
  logic       sclk_prev;   // For edge detection
  logic       cs_prev;     // For select release detection

  // Two flops per pin; SCLK must stay well below sys_clk/4
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pin_meta  <= PIN_IDLE;
      pin_sync  <= PIN_IDLE;
      sclk_prev <= 1'b0;
      cs_prev   <= 1'b1;
    end else begin
      pin_meta  <= {sclk, cs_n, si};
      pin_sync  <= pin_meta;
      sclk_prev <= pin_sync[2];
      cs_prev   <= pin_sync[1];
    end
  end

  wire sclk_s    = pin_sync[2];
  wire cs_s      = pin_sync[1];
  wire si_s      = pin_sync[0];
  wire sclk_rise = sclk_s & ~sclk_prev & ~cs_s;
  wire sclk_fall = ~sclk_s & sclk_prev & ~cs_s;
  wire cs_rise   = cs_s & ~cs_prev;

  // ----------------------------------------------------------------
  // Input framing
  // ----------------------------------------------------------------
  logic [6:0] shift_in;   // Bits of the byte in progress
  logic [2:0] bit_cnt;    // Bit index inside the byte
  logic [2:0] byte_cnt;   // Completed bytes, saturating
  logic [7:0] opcode;     // First byte of the frame
  logic       alt;        // Parity of completed bytes
  logic       addr_lsb;   // Kept address bit of combined read

  wire [7:0] in_byte   = {shift_in, si_s};
  wire       byte_done = sclk_rise & (bit_cnt == BIT_LAST);
  wire       first     = (byte_cnt == CNT_ZERO);
  wire [7:0] cur_op    = first ? in_byte : opcode;

  // Counters restart whenever select is released
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      shift_in <= '0;
      bit_cnt  <= CNT_ZERO;
      byte_cnt <= CNT_ZERO;
      opcode   <= DATA_IDLE;
      alt      <= 1'b0;
      addr_lsb <= 1'b0;
    end else if (cs_s) begin
      bit_cnt  <= CNT_ZERO;
      byte_cnt <= CNT_ZERO;
      alt      <= 1'b0;
    end else if (sclk_rise) begin
      shift_in <= in_byte[6:0];
      bit_cnt  <= bit_cnt + 3'h1;
      if (byte_done) begin
        alt <= ~alt;
        if (first) opcode <= in_byte;
        if (byte_cnt != CNT_SAT) byte_cnt <= byte_cnt + 3'h1;
        if (byte_cnt == CNT_ID_ADDR) addr_lsb <= in_byte[0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Readback data selection
  // ----------------------------------------------------------------
  wire       id_ready  = (byte_cnt >= CNT_ID_ADDR);
  wire       addr_bit  = (byte_cnt == CNT_ID_ADDR) ? in_byte[0] : addr_lsb;
  wire [7:0] cfg_byte  = alt ? config2 : config1;
  wire [7:0] sig_byte  = id_ready ? DEVICE_ID : DATA_IDLE;
  wire [7:0] pair_byte = (alt ^ addr_bit) ? MANUFACTURER_ID : DEVICE_ID;
  wire [7:0] combo_byte = id_ready ? pair_byte : DATA_IDLE;
  wire       is_status = (cur_op == OP_STATUS_READBACK);
  wire       is_config = (cur_op == OP_CONFIG_READBACK);
  wire       is_sig    = (cur_op == OP_SIGNATURE_READ);
  wire       is_combo  = (cur_op == OP_COMBINED_ID_READ);
  wire       is_read   = is_status | is_config | is_sig | is_combo;
  wire [7:0] next_out  = is_status ? status_reg :
                         is_config ? cfg_byte :
                         is_sig    ? sig_byte :
                         is_combo  ? combo_byte : DATA_IDLE;

  logic [7:0] out_byte;   // Word waiting for the next falling edge
  logic       load_pend;  // A word is waiting
  logic       drive;      // SO is being driven

  // Word chosen at the last rising edge, presented at the next falling
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      out_byte  <= DATA_IDLE;
      load_pend <= 1'b0;
      drive     <= 1'b0;
    end else if (cs_s) begin
      load_pend <= 1'b0;
      drive     <= 1'b0;
    end else if (byte_done) begin
      out_byte  <= next_out;
      load_pend <= is_read;
    end else if (sclk_fall && load_pend) begin
      load_pend <= 1'b0;
      drive     <= 1'b1;
    end
  end

  sfcmd_out_shifter #(.WIDTH(8)) u_shift (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .load    (sclk_fall & load_pend),
    .shift   (sclk_fall),
    .data    (out_byte),
    .so      (so)
  );

  assign so_oe_n = ~drive;

  // ----------------------------------------------------------------
  // Single-byte command execution at select release
  // ----------------------------------------------------------------
  logic armed;  // Reset-arm was the immediately previous command

  // Only frames ending exactly on the first byte boundary execute
  wire exec       = cs_rise & (bit_cnt == CNT_ZERO) & (byte_cnt == CNT_OPCODE_ONLY);
  wire any_cmd    = cs_rise & (byte_cnt != CNT_ZERO);
  wire pause_hit  = (opcode == OP_PAUSE_A) | (opcode == OP_PAUSE_B);
  wire resume_hit = (opcode == OP_RESUME_A) | (opcode == OP_RESUME_B);
  wire do_pause   = exec & pause_hit & array_busy & ~ctl.suspended;
  wire do_resume  = exec & resume_hit & ctl.suspended;
  wire do_reset   = exec & (opcode == OP_RESET_MEMORY) & armed;
  wire do_lock    = exec & (opcode == OP_SECURITY_LOCK);
  wire do_wel_set = exec & (opcode == OP_SET_WRITE_LATCH);
  wire do_wel_clr = (exec & (opcode == OP_CLEAR_WRITE_LATCH)) |
                    do_pause | do_reset | do_lock;
  wire do_enter   = exec & (opcode == OP_SECURE_ENTRY);
  wire do_leave   = (exec & (opcode == OP_SECURE_EXIT)) | do_reset;

  // Soft reset clears volatile state but never the lock-down bit
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctl                <= CTL_RESET;
      armed              <= 1'b0;
      suspend_pulse      <= 1'b0;
      resume_pulse       <= 1'b0;
      memory_reset_pulse <= 1'b0;
    end else begin
      suspend_pulse      <= do_pause;
      resume_pulse       <= do_resume;
      memory_reset_pulse <= do_reset;
      if (any_cmd) armed <= exec & (opcode == OP_RESET_ARM);
      if (do_wel_set) ctl.write_enable_latch <= 1'b1;
      else if (do_wel_clr) ctl.write_enable_latch <= 1'b0;
      if (do_enter) ctl.secure_area_mode <= 1'b1;
      else if (do_leave) ctl.secure_area_mode <= 1'b0;
      if (do_lock) ctl.lock_down <= 1'b1;
      if (do_pause) ctl.suspended <= 1'b1;
      else if (do_resume || do_reset) ctl.suspended <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  AST_STATUS_STREAM: assert property (
    byte_done && is_status && !cs_s |=> out_byte == $past(status_reg) && load_pend)
    else $error("status byte not queued");
  AST_CONFIG_FIRST: assert property (
    byte_done && first && is_config |=> out_byte == $past(config1))
    else $error("config register one not first");
  AST_CONFIG_SECOND: assert property (
    byte_done && byte_cnt == CNT_OPCODE_ONLY && is_config |=> out_byte == $past(config2))
    else $error("config register two not second");
  AST_PAUSE: assert property (
    exec && pause_hit && array_busy && !ctl.suspended |=> suspend_pulse && ctl.suspended)
    else $error("suspend not taken");
  AST_RESUME: assert property (
    exec && resume_hit && ctl.suspended |=> resume_pulse && !ctl.suspended)
    else $error("resume not taken");
  AST_SIGNATURE: assert property (
    byte_done && byte_cnt == CNT_ID_ADDR && is_sig |=> out_byte == DEVICE_ID)
    else $error("signature byte wrong");
  AST_COMBO_MFR: assert property (
    byte_done && byte_cnt == CNT_ID_ADDR && is_combo && in_byte == ADDR_MFR_FIRST
    |=> out_byte == MANUFACTURER_ID)
    else $error("manufacturer not first");
  AST_COMBO_DEV: assert property (
    byte_done && byte_cnt == CNT_ID_ADDR && is_combo && in_byte == ADDR_DEV_FIRST
    |=> out_byte == DEVICE_ID)
    else $error("device not first");
  AST_SECURE_ENTRY: assert property (
    do_enter |=> ctl.secure_area_mode)
    else $error("secured area not entered");
  AST_RESET_ARMED: assert property (
    memory_reset_pulse |-> $past(armed) && !ctl.write_enable_latch)
    else $error("reset without arm");
  AST_ARM_CANCEL: assert property (
    any_cmd && opcode != OP_RESET_ARM |=> !armed ##1 !memory_reset_pulse)
    else $error("arm survived another command");
  AST_WRITE_LATCH: assert property (
    do_wel_set |=> ctl.write_enable_latch)
    else $error("write latch not set");
  AST_LOCK_STICKY: assert property (
    ctl.lock_down |=> ctl.lock_down)
    else $error("lock-down bit cleared");

  COV_STATUS: cover property (byte_done && is_status ##[1:200] byte_done);
  COV_COMBO:  cover property (byte_done && is_combo && byte_cnt == CNT_ID_ADDR);
  COV_RESET:  cover property (memory_reset_pulse);
  COV_PAUSE:  cover property (suspend_pulse ##[1:1000] resume_pulse);

endmodule : sfcmd_top
`default_nettype wire

// >>> sfcmd_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// Serial host, mode 0, slow phases
// ----------------------------------------------------------------
module sfcmd_host_model (
  input  wire logic sys_clk,
  input  wire logic so,
  input  wire logic so_oe_n,
  output logic      sclk,
  output logic      cs_n,
  output logic      si
);
  logic [7:0] rx [0:3];  // Bytes read back after the command bytes
  logic       oe_ok;     // Enable low at every read capture

  // Clock rests low, no device selected
  initial begin
    sclk <= 1'b0;
    cs_n <= 1'b1;
    si   <= 1'b0;
  end

  // One bit; four cycles a phase keep the synchronisers well ahead
  task automatic bit_cycle(input logic b, output logic r);
    si <= b;
    repeat (4) @(negedge sys_clk);
    sclk <= 1'b1;
    r = so;  // Device bit stands until its synced fall
    repeat (4) @(negedge sys_clk);
    sclk <= 1'b0;
  endtask : bit_cycle

  // Whole frame; only opcodes of the defined set are ever passed in
  task automatic run(input logic [31:0] tx, input int ntx, input int nrx);
    logic r;
    @(negedge sys_clk);
    cs_n  <= 1'b0;
    oe_ok = 1'b1;
    repeat (4) @(negedge sys_clk);
    // Dummy and address bytes go out whole, MSB first
    for (int i = 0; i < ntx * 8; i++) begin
      bit_cycle(tx[31-i], r);
    end
    for (int n = 0; n < nrx; n++) begin
      for (int i = 7; i >= 0; i--) begin
        bit_cycle(1'b0, r);
        rx[n][i] = r;
        if (so_oe_n !== 1'b0) oe_ok = 1'b0;
      end
    end
    repeat (4) @(negedge sys_clk);
    cs_n <= 1'b1;
    si   <= ~si;  // Released line never shows the last value
    repeat (10) @(negedge sys_clk);
  endtask : run
endmodule : sfcmd_host_model
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import sfcmd_pkg::*;
();
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [7:0] MFR_ID = 8'h3e;  // Arbitrary value
  localparam logic [7:0] DEV_ID = 8'hc7;  // Arbitrary value
  logic          sys_clk;
  logic          resetn     = 1'b0;
  logic [7:0]    status_reg = 8'h3c;
  logic [7:0]    config1    = 8'h81;
  logic [7:0]    config2    = 8'h42;
  logic          array_busy = 1'b0;
  logic          sclk, cs_n, si, so, so_oe_n;
  sfcmd_ctl_type ctl;
  logic          suspend_pulse, resume_pulse, memory_reset_pulse;
  logic [7:0]    n_sus = 8'h00;  // Pulse counts seen by the bench
  logic [7:0]    n_res = 8'h00;
  logic [7:0]    n_rst = 8'h00;
  int            bad_count = 0;
  int            checks = 0;

  sfcmd_top #(.MANUFACTURER_ID(MFR_ID), .DEVICE_ID(DEV_ID)) dut (
    .sys_clk(sys_clk), .resetn(resetn), .sclk(sclk), .cs_n(cs_n), .si(si),
    .status_reg(status_reg), .config1(config1), .config2(config2),
    .array_busy(array_busy), .so(so), .so_oe_n(so_oe_n), .ctl(ctl),
    .suspend_pulse(suspend_pulse), .resume_pulse(resume_pulse),
    .memory_reset_pulse(memory_reset_pulse));

  sfcmd_host_model host (
    .sys_clk(sys_clk), .so(so), .so_oe_n(so_oe_n), .sclk(sclk), .cs_n(cs_n), .si(si));

  // 25 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Count one-cycle pulses so a stuck or double pulse shows
  always @(posedge sys_clk) begin
    if (suspend_pulse === 1'b1) n_sus <= n_sus + 8'h01;
    if (resume_pulse === 1'b1) n_res <= n_res + 8'h01;
    if (memory_reset_pulse === 1'b1) n_rst <= n_rst + 8'h01;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cmd(input logic [7:0] op);
    host.run({op, 24'h000000}, 1, 0);
  endtask : cmd

  task automatic tally_and_finish();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Readbacks repeat or alternate while the host keeps clocking
  task automatic t_read();
    host.run({OP_STATUS_READBACK, 24'h0}, 1, 2);
    chk(host.rx[0], 8'h3c);
    chk(host.rx[1], 8'h3c);
    chk({7'h0, host.oe_ok}, 8'h01);
    host.run({OP_CONFIG_READBACK, 24'h0}, 1, 3);
    chk(host.rx[0], 8'h81);
    chk(host.rx[1], 8'h42);
    chk(host.rx[2], 8'h81);
    host.run({OP_SIGNATURE_READ, 24'h0}, 4, 2);
    chk(host.rx[0], DEV_ID);
    chk(host.rx[1], DEV_ID);
    for (int a = 0; a < 2; a++) begin
      host.run({OP_COMBINED_ID_READ, 16'h0, 8'(a)}, 4, 2);
      chk(host.rx[0], (a == 1) ? DEV_ID : MFR_ID);
      chk(host.rx[1], (a == 1) ? MFR_ID : DEV_ID);
    end
  endtask : t_read

  // Single-byte mode switches
  task automatic t_modes();
    cmd(OP_SET_WRITE_LATCH);
    chk({7'h0, ctl.write_enable_latch}, 8'h01);
    cmd(OP_CLEAR_WRITE_LATCH);
    chk({7'h0, ctl.write_enable_latch}, 8'h00);
    cmd(OP_SECURE_ENTRY);
    chk({7'h0, ctl.secure_area_mode}, 8'h01);
    cmd(OP_SECURE_EXIT);
    chk({7'h0, ctl.secure_area_mode}, 8'h00);
  endtask : t_modes

  // Both pause and both resume codes while work is in progress
  task automatic t_suspend();
    logic [7:0] ps [0:1];
    logic [7:0] rs [0:1];
    ps = '{OP_PAUSE_A, OP_PAUSE_B};
    rs = '{OP_RESUME_A, OP_RESUME_B};
    // Nothing to pause or resume while the array is idle
    cmd(OP_PAUSE_A);
    chk(n_sus, 8'h00);
    chk({7'h0, ctl.suspended}, 8'h00);
    cmd(OP_RESUME_A);
    chk(n_res, 8'h00);
    array_busy = 1'b1;
    for (int k = 0; k < 2; k++) begin
      cmd(ps[k]);
      chk(n_sus, 8'(k + 1));
      chk({7'h0, ctl.suspended}, 8'h01);
      cmd(rs[k]);
      chk(n_res, 8'(k + 1));
      chk({7'h0, ctl.suspended}, 8'h00);
    end
    array_busy = 1'b0;
  endtask : t_suspend

  // Arm then reset works; anything in between cancels the arm
  task automatic t_reset();
    cmd(OP_SET_WRITE_LATCH);
    cmd(OP_RESET_ARM);
    cmd(OP_RESET_MEMORY);
    chk(n_rst, 8'h01);
    chk({7'h0, ctl.write_enable_latch}, 8'h00);
    cmd(OP_RESET_ARM);
    cmd(OP_SET_WRITE_LATCH);
    cmd(OP_RESET_MEMORY);
    chk(n_rst, 8'h01);
    chk({7'h0, ctl.write_enable_latch}, 8'h01);
  endtask : t_reset

  // Lock-down survives a memory reset
  task automatic t_lock();
    cmd(OP_SECURITY_LOCK);
    chk({7'h0, ctl.lock_down}, 8'h01);
    cmd(OP_RESET_ARM);
    cmd(OP_RESET_MEMORY);
    chk(n_rst, 8'h02);
    chk({7'h0, ctl.lock_down}, 8'h01);
  endtask : t_lock

  // ----------------------------------------------------------------
  // Sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(negedge sys_clk);
    resetn = 1'b1;
    repeat (4) @(negedge sys_clk);
    t_read();
    t_modes();
    t_suspend();
    t_reset();
    t_lock();
    tally_and_finish();
  end

  // About 3.3k cycles expected; a hang stops well past that
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
